//--- inc/sep_pkg.sv
// constants shared by both ends of the serial memory command link
// assumes: one 25 MHz core clock, serial link clock generated by the host end
`default_nettype none
package sep_pkg;
  localparam int OPC_W = 4;
  localparam int ADDR_W8 = 7;
  localparam int ADDR_W16 = 6;
  localparam int ADDR_MAX = 7;
  localparam int DATA_W = 16;
  localparam int DATA_W8 = 8;
  localparam int WORDS = 128;
  localparam int INSTR_LEN8 = 12;
  localparam int INSTR_LEN16 = 11;
  localparam int CNT_W = 5;
  localparam logic [3:0] OPC_READ = 4'h8;
  localparam logic [2:0] OPC_PROG_LOW = 3'h4; // first opcode bit is don't care
  localparam logic [3:0] OPC_UNLOCK = 4'h3;
  localparam logic [3:0] OPC_LOCK = 4'h0;
  localparam logic [3:0] OPC_BULK = 4'h2;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int CLK_HZ = 25000000;
  localparam int CYCLE_MS = 40; // self-timed cycle, within 20..75 ms
  localparam int CYCLE_CNT = CLK_HZ / 1000 * CYCLE_MS;
  localparam int TIMER_W = 21;
  localparam int SCK_DIV = 50; // half period in core clocks: 250 kHz link
  localparam int DIV_W = 6;
  typedef enum logic [2:0] {SEP_CMD_READ, SEP_CMD_PROG, SEP_CMD_UNLOCK, SEP_CMD_LOCK,
                            SEP_CMD_BULK} sep_cmd_t;
endpackage
`default_nettype wire

//--- inc/sep_if.sv
// serial command link between host controller and memory device
// assumes: serial output is tri-stated via enable, bench resolves sharing
`default_nettype none
interface sep_if;
  logic sel;        // chip select, high active
  logic sck;        // serial clock made by the host
  logic serial_in;  // host to device data
  logic dout;       // device data value
  logic dout_oe_n;  // low while the device drives its output
  logic ready;      // high ready, low busy
  modport device (input sel, input sck, input serial_in, output dout, output dout_oe_n, output ready);
  modport host (output sel, output sck, output serial_in, input dout, input dout_oe_n, input ready);
endinterface
`default_nettype wire

//--- design/sep_device.sv
// memory device end: serial instruction decoder, array and self-timed cycle
// assumes: link pins synchronous to core_clk_in; sck edges detected in core clock
`default_nettype none
module sep_device #(
  parameter int CYCLE_CYCLES = sep_pkg::CYCLE_CNT
) (
  input  wire logic core_clk_in,
  input  wire logic nrst_in,
  input  wire logic array_width_select_in,
  sep_if.device     link
);
  typedef enum logic [2:0] {SEP_IDLE, SEP_HDR, SEP_DATA, SEP_RD, SEP_BUSY, SEP_DONE} sep_state_t;
  typedef struct packed {
    sep_state_t  st;
    logic        sck_q;
    logic [sep_pkg::CNT_W-1:0] cnt;
    logic [10:0] hdr;
    logic [15:0] sh;
    logic        unlocked;
    logic        bulk;
    logic [6:0]  addr;
    logic [sep_pkg::TIMER_W-1:0] tmr;
    logic        dout;
    logic        oe_n;
    logic        ready;
  } sep_dev_t;

  sep_dev_t r;
  sep_dev_t next_r;
  logic [7:0] mem [sep_pkg::WORDS];
  logic       wr_en;
  logic       wr_all;
  logic [6:0] wr_addr;
  logic [7:0] wr_lo;
  logic [7:0] wr_hi;

  logic        wide;
  logic        rise;
  logic        fall;
  logic [3:0]  opc;
  logic [6:0]  a_in;
  logic [3:0]  hdr_len;
  logic [4:0]  dlen;
  logic [10:0] hdr_nx;

  always_comb begin
    wide    = array_width_select_in;
    rise    = link.sck & ~r.sck_q;
    fall    = ~link.sck & r.sck_q;
    hdr_nx  = {r.hdr[9:0], link.serial_in};
    hdr_len = wide ? 4'(sep_pkg::OPC_W + sep_pkg::ADDR_W16) : 4'(sep_pkg::OPC_W + sep_pkg::ADDR_W8);
    dlen    = wide ? 5'(sep_pkg::DATA_W) : 5'(sep_pkg::DATA_W8);
    opc     = wide ? hdr_nx[9:6] : hdr_nx[10:7];
    a_in    = wide ? {1'b0, hdr_nx[5:0]} : hdr_nx[6:0];
    next_r  = r;
    next_r.sck_q = link.sck;
    wr_en   = 1'b0;
    wr_all  = 1'b0;
    wr_addr = r.addr;
    wr_lo   = r.sh[7:0];
    wr_hi   = r.sh[15:8];
    case (r.st)
      SEP_IDLE: begin
        if (link.sel && rise && link.serial_in) begin
          next_r.st  = SEP_HDR;
          next_r.cnt = '0;
          next_r.hdr = '0;
        end
      end
      SEP_HDR: begin
        if (rise) begin
          next_r.hdr = hdr_nx;
          next_r.cnt = r.cnt + 5'd1;
          if (r.cnt == 5'(hdr_len - 4'd1)) begin
            next_r.addr = a_in;
            next_r.cnt  = '0;
            next_r.st   = SEP_DONE;
            if (opc == sep_pkg::OPC_READ) begin
              next_r.st = SEP_RD;
              next_r.sh = wide ? {mem[{a_in[5:0], 1'b1}], mem[{a_in[5:0], 1'b0}]}
                               : {mem[a_in], 8'h00};
              next_r.dout = 1'b0;
            end else if (opc[2:0] == sep_pkg::OPC_PROG_LOW) begin
              if (r.unlocked) begin
                next_r.st = SEP_DATA;
              end
            end else if (opc == sep_pkg::OPC_UNLOCK) begin
              next_r.unlocked = 1'b1;
            end else if (opc == sep_pkg::OPC_LOCK) begin
              next_r.unlocked = 1'b0;
            end else if (opc == sep_pkg::OPC_BULK && r.unlocked) begin
              next_r.bulk  = 1'b1;
              next_r.st    = SEP_BUSY;
              next_r.tmr   = '0;
              next_r.ready = 1'b0;
            end
          end
        end
      end
      SEP_DATA: begin
        if (rise) begin
          next_r.sh  = {r.sh[14:0], link.serial_in}; // msb first
          next_r.cnt = r.cnt + 5'd1;
          if (r.cnt == dlen - 5'd1) begin
            next_r.bulk  = 1'b0;
            next_r.st    = SEP_BUSY;
            next_r.tmr   = '0;
            next_r.ready = 1'b0;
          end
        end
      end
      SEP_RD: begin
        next_r.oe_n = 1'b0;
        if (rise) begin
          next_r.dout = r.sh[15];
          next_r.sh   = {r.sh[14:0], 1'b0};
        end
      end
      SEP_BUSY: begin
        next_r.tmr = r.tmr + 1'b1;
        if (r.tmr == sep_pkg::TIMER_W'(CYCLE_CYCLES - 1)) begin
          // erase and write collapse into one store at the end of the cycle
          wr_en  = 1'b1;
          wr_all = r.bulk;
          if (!wide) begin
            wr_lo = r.sh[7:0];
          end else begin
            wr_addr = {r.addr[5:0], 1'b0};
          end
          next_r.ready = 1'b1;
          next_r.st    = SEP_DONE;
        end
      end
      SEP_DONE: begin
      end
      default: next_r.st = SEP_IDLE;
    endcase
    // busy cycle runs on without select; the rest ends at deselect
    if (!link.sel && r.st != SEP_BUSY) begin
      next_r.st   = SEP_IDLE;
      next_r.oe_n = 1'b1;
      next_r.dout = 1'b0;
    end
    if (fall && r.st == SEP_RD) begin
      next_r.oe_n = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r          <= '0;
      r.st       <= SEP_IDLE;
      r.oe_n     <= 1'b1;
      r.ready    <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // array has no reset: contents are nonvolatile
  always_ff @(posedge core_clk_in) begin
    for (int i = 0; i < sep_pkg::WORDS; i++) begin
      if (wr_en && (wr_all || 7'(i) == wr_addr)) begin
        mem[i] <= wr_all ? sep_pkg::ERASED_BYTE : wr_lo;
      end else if (wr_en && wide && !wr_all && 7'(i) == (wr_addr | 7'h01)) begin
        mem[i] <= wr_hi;
      end
    end
  end

  assign link.dout      = r.dout;
  assign link.dout_oe_n = r.oe_n;
  assign link.ready     = r.ready;
endmodule
`default_nettype wire

//--- design/sep_host.sv
// host end: turns one user request into a serial instruction frame
// assumes: user waits for req_ready_out before the next request
`default_nettype none
module sep_host (
  input  wire logic               core_clk_in,
  input  wire logic               nrst_in,
  input  wire logic               wide_in,
  input  wire logic               req_valid_in,
  input  wire sep_pkg::sep_cmd_t  req_cmd_in,
  input  wire logic [6:0]         req_addr_in,
  input  wire logic [15:0]        req_data_in,
  output logic                    req_ready_out,
  output logic                    rd_valid_out,
  output logic [15:0]             rd_data_out,
  sep_if.host                     link
);
  typedef enum logic [1:0] {SEH_IDLE, SEH_SHIFT, SEH_WAIT} seh_state_t;
  typedef struct packed {
    seh_state_t st;
    logic       sel;
    logic       sck;
    logic       sdo;
    logic [sep_pkg::DIV_W-1:0] div;
    logic [5:0] left;
    logic [6:0] rdleft;
    logic [27:0] frame;
    logic       is_rd;
    logic       is_busy;
    logic [15:0] rd;
    logic       rdv;
    logic       rdy;
  } seh_t;

  seh_t r;
  seh_t next_r;
  logic [3:0]  opc;
  logic [27:0] fr;
  logic [5:0]  n;
  logic        tick;

  always_comb begin
    next_r = r;
    next_r.rdv = 1'b0;
    tick = r.div == sep_pkg::DIV_W'(sep_pkg::SCK_DIV - 1);
    next_r.div = tick ? '0 : r.div + 1'b1;
    case (req_cmd_in)
      sep_pkg::SEP_CMD_READ:   opc = sep_pkg::OPC_READ;
      sep_pkg::SEP_CMD_PROG:   opc = {1'b0, sep_pkg::OPC_PROG_LOW};
      sep_pkg::SEP_CMD_UNLOCK: opc = sep_pkg::OPC_UNLOCK;
      sep_pkg::SEP_CMD_BULK:   opc = sep_pkg::OPC_BULK;
      default:                 opc = sep_pkg::OPC_LOCK;
    endcase
    fr = '0;
    n  = '0;
    case (r.st)
      SEH_IDLE: begin
        if (req_valid_in && r.rdy && link.ready) begin
          // zero address for unlock, lock and bulk erase
          if (wide_in) begin
            fr = {1'b1, opc, (req_cmd_in == sep_pkg::SEP_CMD_READ || req_cmd_in == sep_pkg::SEP_CMD_PROG)
                  ? req_addr_in[5:0] : 6'h00, req_data_in, 1'b0};
            n  = 6'(sep_pkg::INSTR_LEN16);
          end else begin
            fr = {1'b1, opc, (req_cmd_in == sep_pkg::SEP_CMD_READ || req_cmd_in == sep_pkg::SEP_CMD_PROG)
                  ? req_addr_in : 7'h00, req_data_in[7:0], 8'h00};
            n  = 6'(sep_pkg::INSTR_LEN8);
          end
          if (req_cmd_in == sep_pkg::SEP_CMD_PROG) begin
            n = n + (wide_in ? 6'(sep_pkg::DATA_W) : 6'(sep_pkg::DATA_W8));
          end
          next_r.frame   = fr;
          next_r.left    = n;
          next_r.is_rd   = req_cmd_in == sep_pkg::SEP_CMD_READ;
          next_r.is_busy = req_cmd_in == sep_pkg::SEP_CMD_PROG || req_cmd_in == sep_pkg::SEP_CMD_BULK;
          next_r.rdleft  = wide_in ? 7'(sep_pkg::DATA_W + 1) : 7'(sep_pkg::DATA_W8 + 1);
          next_r.rd      = '0;
          next_r.sel     = 1'b1;
          next_r.sdo     = 1'b0;
          next_r.rdy     = 1'b0;
          next_r.div     = '0;
          next_r.st      = SEH_SHIFT;
        end
      end
      SEH_SHIFT: begin
        if (tick) begin
          if (!r.sck) begin
            if (r.left != 6'd0) begin
              next_r.sdo   = r.frame[27];
              next_r.frame = {r.frame[26:0], 1'b0};
              next_r.left  = r.left - 6'd1;
              next_r.sck   = 1'b1;
            end else if (r.is_rd && r.rdleft != 7'd0) begin
              next_r.sdo = 1'b0;
              next_r.sck = 1'b1;
            end else begin
              next_r.sel = 1'b0;
              next_r.st  = r.is_busy ? SEH_WAIT : SEH_IDLE;
              next_r.rdy = ~r.is_busy;
              next_r.rdv = r.is_rd;
            end
          end else begin
            next_r.sck = 1'b0;
            // last bit already taken at the rise: lower the line before the dummy zero
            if (r.left == 6'd0) begin
              next_r.sdo = 1'b0;
            end
            if (r.left == 6'd0 && r.is_rd && r.rdleft != 7'd0) begin
              // sample late in the high phase, device updated at the rise
              next_r.rd     = {r.rd[14:0], link.dout};
              next_r.rdleft = r.rdleft - 7'd1;
            end
          end
        end
      end
      SEH_WAIT: begin
        if (link.ready && tick) begin
          next_r.st  = SEH_IDLE;
          next_r.rdy = 1'b1;
        end
      end
      default: next_r.st = SEH_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r     <= '0;
      r.st  <= SEH_IDLE;
      r.rdy <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign link.sel       = r.sel;
  assign link.sck       = r.sck;
  assign link.serial_in = r.sdo;
  assign req_ready_out  = r.rdy;
  assign rd_valid_out   = r.rdv;
  assign rd_data_out    = r.rd;
endmodule
`default_nettype wire

//--- verification/sep_checker.sv
// concurrent checks on the serial link between host and device ends
// assumes: all link signals are registered on the core clock
`default_nettype none
module sep_checker #(
  parameter int CYC = 200
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic sel,
  input wire logic sck,
  input wire logic serial_in,
  input wire logic dout,
  input wire logic dout_oe_n,
  input wire logic ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // helper state and assertions
  // ----------------------------------------
  int   busy_cnt;
  logic first;
  logic sel_q;
  logic sck_q;
  // edges found from own flops, no sampled-value call outside a property
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      busy_cnt <= 0;
      first    <= 1'b0;
      sel_q    <= 1'b0;
      sck_q    <= 1'b0;
    end else begin
      busy_cnt <= ready ? 0 : busy_cnt + 1;
      sel_q    <= sel;
      sck_q    <= sck;
      first    <= (sel && !sel_q) ? 1'b1 : ((sck && !sck_q) ? 1'b0 : first);
    end
  end
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!nrst_in);
  a_idle_no_drive: assert property (!sel && !$past(sel) |-> dout_oe_n)
    else $error("output driven while deselected");
  a_deselect_float: assert property ($fell(sel) |-> ##[0:2] dout_oe_n)
    else $error("output still driven after deselect");
  a_dout_sck_high: assert property (!dout_oe_n && sel && $changed(dout) |-> sck)
    else $error("output changed while serial clock low");
  a_dummy_zero: assert property ($fell(dout_oe_n) |-> !dout)
    else $error("first driven bit not zero");
  a_busy_length: assert property ($rose(ready) |-> busy_cnt >= CYC - 2 && busy_cnt <= CYC + 2)
    else $error("busy period length wrong");
  a_busy_cap: assert property (busy_cnt <= CYC + 2)
    else $error("busy period too long");
  a_no_frame_busy: assert property (!ready |-> !$rose(sel))
    else $error("frame started while busy");
  a_sck_idle: assert property (!sel |-> !sck)
    else $error("serial clock moving while deselected");
  a_start_one: assert property ($rose(sck) && first |-> serial_in)
    else $error("first bit of frame not one");
  a_dummy_quiet: assert property (!dout_oe_n && !sck |-> !serial_in)
    else $error("host input line high while device drives output");
endmodule
`default_nettype wire

//--- verification/test_serial_eeprom_1k_command_port.sv
// bench joining host and device ends over one link
// assumes: ends, package and interface compiled first
`default_nettype none
module test_serial_eeprom_1k_command_port;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals, instances, monitors
  // ----------------------------------------
  localparam int CYC = 200;
  localparam int LIM = 20000;
  logic              clk        = 1'b0;
  logic              nrst       = 1'b0;
  logic              wide       = 1'b1;
  logic              valid      = 1'b0;
  sep_pkg::sep_cmd_t cmd        = sep_pkg::SEP_CMD_READ;
  logic [6:0]        addr       = 7'h00;
  logic [15:0]       data       = 16'h0000;
  logic              req_ready;
  logic              rd_valid;
  logic [15:0]       rd_data;
  logic [15:0]       got;
  logic [31:0]       frame      = 32'h0;
  int                nbits      = 0;
  logic              busy_seen  = 1'b0;
  logic              mon_sck_q  = 1'b0;
  logic              mon_sel_q  = 1'b0;
  int                n_mismatch = 0;
  int                n_checks   = 0;
  sep_if lnk();
  always #20 clk = ~clk;
`define CHK(nm, exp, act) \
  n_checks++; \
  if ((act) !== (exp)) begin \
    n_mismatch++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, exp, act); \
  end
  sep_device #(.CYCLE_CYCLES(CYC)) i_sep_device (.core_clk_in(clk), .nrst_in(nrst),
    .array_width_select_in(wide), .link(lnk));
  sep_host i_sep_host (.core_clk_in(clk), .nrst_in(nrst), .wide_in(wide), .req_valid_in(valid),
    .req_cmd_in(cmd), .req_addr_in(addr), .req_data_in(data), .req_ready_out(req_ready),
    .rd_valid_out(rd_valid), .rd_data_out(rd_data), .link(lnk));
  sep_checker #(.CYC(CYC)) i_sep_checker (.core_clk_in(clk), .nrst_in(nrst), .sel(lnk.sel),
    .sck(lnk.sck), .serial_in(lnk.serial_in), .dout(lnk.dout), .dout_oe_n(lnk.dout_oe_n),
    .ready(lnk.ready));
  // frame monitor on the core clock: sck and data leave the host together
  always @(posedge clk) begin
    mon_sck_q <= lnk.sck;
    mon_sel_q <= lnk.sel;
    if (lnk.sel === 1'b1 && mon_sel_q !== 1'b1) begin
      nbits <= 0;
    end else if (lnk.sel === 1'b1 && lnk.sck === 1'b1 && mon_sck_q !== 1'b1) begin
      frame <= {frame[30:0], lnk.serial_in};
      nbits <= nbits + 1;
    end
  end
  always @(posedge clk) begin
    if (lnk.ready === 1'b0) busy_seen <= 1'b1;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic do_reset;
    nrst = 1'b0;
    repeat (10) @(posedge clk);
    #1 nrst = 1'b1;
  endtask
  // one request, waits for req_ready again (after the busy cycle for program and bulk erase); read data lands in got
  task automatic op(input sep_pkg::sep_cmd_t c, input logic [6:0] a, input logic [15:0] d);
    int i;
    i = 0;
    got = 16'hXXXX;
    while (!(req_ready === 1'b1 && lnk.ready === 1'b1) && i < LIM) begin
      @(posedge clk);
      #1 i++;
    end
    cmd   = c;
    addr  = a;
    data  = d;
    valid = 1'b1;
    @(posedge clk);
    #1 valid = 1'b0;
    do begin
      @(posedge clk);
      #1 i++;
      if (rd_valid === 1'b1) got = rd_data;
    end while (req_ready !== 1'b1 && i < LIM);
    if (i >= LIM) begin
      n_mismatch++;
      print_verdict;
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_erase_all;
    op(sep_pkg::SEP_CMD_UNLOCK, 7'h00, 16'h0000);
    `CHK("unlock len", 11, nbits)
    `CHK("unlock frame", 11'h4C0, frame[10:0])
    busy_seen = 1'b0;
    op(sep_pkg::SEP_CMD_BULK, 7'h00, 16'h0000);
    `CHK("erase frame", 11'h480, frame[10:0])
    op(sep_pkg::SEP_CMD_READ, 7'h3F, 16'h0000);
    `CHK("erase busy", 1'b1, busy_seen)
    `CHK("erased word", 16'hFFFF, got)
  endtask
  task automatic t_prog_read;
    op(sep_pkg::SEP_CMD_PROG, 7'h05, 16'h1234);
    `CHK("prog len", 27, nbits)
    `CHK("prog frame", 27'h5051234, frame[26:0])
    op(sep_pkg::SEP_CMD_READ, 7'h05, 16'h0000);
    `CHK("read back", 16'h1234, got)
  endtask
  // locked device must not modify nor go busy
  task automatic t_locked;
    op(sep_pkg::SEP_CMD_LOCK, 7'h00, 16'h0000);
    `CHK("lock frame", 11'h400, frame[10:0])
    busy_seen = 1'b0;
    op(sep_pkg::SEP_CMD_PROG, 7'h05, 16'h0000);
    op(sep_pkg::SEP_CMD_BULK, 7'h00, 16'h0000);
    op(sep_pkg::SEP_CMD_READ, 7'h05, 16'h0000);
    `CHK("locked busy", 1'b0, busy_seen)
    `CHK("locked word", 16'h1234, got)
  endtask
  // strap low; reset also relocks the device
  task automatic t_byte_mode;
    wide = 1'b0;
    do_reset;
    `CHK("reset ready", 1'b1, lnk.ready)
    `CHK("reset float", 1'b1, lnk.dout_oe_n)
    busy_seen = 1'b0;
    op(sep_pkg::SEP_CMD_PROG, 7'h7F, 16'h0000);
    `CHK("relocked busy", 1'b0, busy_seen)
    op(sep_pkg::SEP_CMD_UNLOCK, 7'h00, 16'h0000);
    `CHK("byte unlock len", 12, nbits)
    `CHK("byte unlock frame", 12'h980, frame[11:0])
    op(sep_pkg::SEP_CMD_PROG, 7'h7F, 16'h00A5);
    `CHK("byte prog frame", 20'hA7FA5, frame[19:0])
    op(sep_pkg::SEP_CMD_READ, 7'h7F, 16'h0000);
    `CHK("byte read", 16'h00A5, got)
    op(sep_pkg::SEP_CMD_PROG, 7'h7F, 16'h00FF);
    op(sep_pkg::SEP_CMD_READ, 7'h7F, 16'h0000);
    `CHK("ones prog", 16'h00FF, got)
  endtask
  initial begin
    do_reset;
    t_erase_all;
    t_prog_read;
    t_locked;
    t_byte_mode;
    print_verdict;
  end
endmodule
`default_nettype wire
